// ==== src/issue_ctrl.sv ====
// Scalar/vector instruction issue control with result conflict checking.
`timescale 1ns/100ps
`default_nettype none
module issue_ctrl
  import issue_pkg::*;
#(
  parameter int N_RAR = NUM_RAR
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic              CAND_VALID,
  input  wire logic [7:0]        CAND_OPCODE,
  input  wire logic [WORD_W-1:0] CAND_WORD,
  input  wire logic [GDES_W-1:0] CAND_GBITS,
  input  wire logic [ADDR_W-1:0] CAND_SRC_A,
  input  wire logic              CAND_USE_A,
  input  wire logic [ADDR_W-1:0] CAND_SRC_B,
  input  wire logic              CAND_USE_B,
  input  wire logic [ADDR_W-1:0] CAND_DEST,
  input  wire logic              CAND_HAS_DEST,
  input  wire logic [LAT_W-1:0]  CAND_LATENCY,
  input  wire logic              CAND_MEM_REF,
  input  wire logic              CAND_STACK_FETCH,
  input  wire logic [DESC_W-1:0] CAND_DESC,
  input  wire logic              CAND_SETS_FLAG,
  input  wire logic [7:0]        CAND_FLAGS,
  input  wire logic              MEM_CONFLICT,
  input  wire logic              MONITOR_MODE,
  input  wire logic              INTERRUPT,
  input  wire logic              VEC_RF_FREE,
  input  wire logic              VEC_DONE,
  output logic                   ISSUE,
  output logic                   STALL,
  output logic                   VEC_START,
  output logic [7:0]             VEC_OPCODE,
  output logic [DESC_W-1:0]      VEC_DESC,
  output logic                   ILL_TRAP,
  output logic                   FLAG_VALID,
  output logic [7:0]             FLAG_DATA,
  output logic                   SAVE_VALID,
  output logic [PC_W-1:0]        SAVE_SCALAR_PC,
  output logic [PC_W-1:0]        SAVE_VECTOR_PC,
  output logic [7:0]             SAVE_VOPCODE,
  output logic [GDES_W-1:0]      SAVE_GBITS,
  output logic [WORD_W-1:0]      SAVE_CIR
);

  localparam int IDX_W = $clog2(N_RAR);
  localparam int CHAIN_W = 2 ** LAT_W;

  // The slot allocator and the conflict fan-in are sized for this count.
  if (N_RAR != NUM_RAR) begin : g_bad_rar
    $error("issue_ctrl: N_RAR must equal 16");
  end

  logic                rst_meta_ff;
  logic                rst_n;
  logic                rar_valid_ff [N_RAR];
  logic [ADDR_W-1:0]   rar_addr_ff  [N_RAR];
  logic [LAT_W-1:0]    rar_cnt_ff   [N_RAR];
  logic [N_RAR-1:0]    src_hit;
  logic [N_RAR-1:0]    out_hit;
  logic [CHAIN_W-1:0]  chain_ff;
  logic [CHAIN_W-1:0]  nxt_chain;
  logic                free_any;
  logic [IDX_W-1:0]    free_idx;
  logic [LAT_W-1:0]    lat;
  class_e              cls;
  vstate_e             vs_ff;
  logic                as_vec;
  logic                src_conf;
  logic                out_conf;
  logic                wr_conf;
  logic                vrf_conf;
  logic                common_ok;
  logic                scalar_ok;
  logic                vec_go;
  logic                alloc;
  logic [ADDR_W-1:0]   vreg_a_ff;
  logic [ADDR_W-1:0]   vreg_b_ff;
  logic [ADDR_W-1:0]   vreg_d_ff;
  logic [GDES_W-1:0]   vgbits_ff;
  logic [PC_W-1:0]     scalar_pc_ff;
  logic [PC_W-1:0]     vector_pc_ff;
  logic [WORD_W-1:0]   cir_ff;

  // Reset is released through two flops; only the second copy is used.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // A zero latency would mark the timing chain 15 cycles out, so it counts as one cycle.
  assign lat = (CAND_LATENCY == '0) ? LAT_W'(1) : CAND_LATENCY;
  assign cls = classify(CAND_OPCODE);
  // Illegal codes belong to the vector unit outside monitor mode.
  assign as_vec = (cls == CLS_VECTOR) ||
                  (cls == CLS_ILLEGAL && !MONITOR_MODE);

  // Lowest free result address register wins the allocation.
  always_comb begin
    free_any = 1'b0;
    free_idx = '0;
    for (int i = N_RAR - 1; i >= 0; i--) begin
      if (!rar_valid_ff[i]) begin
        free_any = 1'b1;
        free_idx = IDX_W'(i);
      end
    end
  end

  // Each entry counts down to the cycle its result enters the file.
  for (genvar i = 0; i < N_RAR; i++) begin : g_rar
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        rar_valid_ff[i] <= 1'b0;
        rar_addr_ff[i]  <= 8'h0;
        rar_cnt_ff[i]   <= 4'h0;
      end else if (alloc && free_idx == IDX_W'(i)) begin
        rar_valid_ff[i] <= 1'b1;
        rar_addr_ff[i]  <= CAND_DEST;
        rar_cnt_ff[i]   <= lat;
      end else if (rar_valid_ff[i]) begin
        rar_cnt_ff[i]   <= rar_cnt_ff[i] - 4'h1;
        rar_valid_ff[i] <= rar_cnt_ff[i] > 4'h1;
      end
    end
    // Sources are matched against every entry in the same cycle.
    assign src_hit[i] = rar_valid_ff[i] &&
      ((CAND_USE_A && rar_addr_ff[i] == CAND_SRC_A) ||
       (CAND_USE_B && rar_addr_ff[i] == CAND_SRC_B));
    // An older result landing no earlier than one cycle before ours must go first.
    assign out_hit[i] = rar_valid_ff[i] && CAND_HAS_DEST &&
      rar_addr_ff[i] == CAND_DEST && rar_cnt_ff[i] >= lat;
  end

  assign src_conf = |src_hit;
  assign out_conf = |out_hit;
  assign wr_conf  = CAND_HAS_DEST && chain_ff[lat];

  // Timing chain: bit k marks a file write k cycles from now.
  always_comb begin
    nxt_chain = {1'b0, chain_ff[CHAIN_W-1:1]};
    if (alloc) begin
      nxt_chain = nxt_chain | (CHAIN_W'(1) << (lat - 4'h1));
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      chain_ff <= 16'h0;
    end else begin
      chain_ff <= nxt_chain;
    end
  end

  // Scalar overlap needs no clash with the vector op's registers.
  assign vrf_conf = (CAND_USE_A && (CAND_SRC_A == vreg_a_ff ||
                     CAND_SRC_A == vreg_b_ff || CAND_SRC_A == vreg_d_ff)) ||
                    (CAND_USE_B && (CAND_SRC_B == vreg_a_ff ||
                     CAND_SRC_B == vreg_b_ff || CAND_SRC_B == vreg_d_ff)) ||
                    (CAND_HAS_DEST && (CAND_DEST == vreg_a_ff ||
                     CAND_DEST == vreg_b_ff || CAND_DEST == vreg_d_ff));

  // Every check must be clear; a conflict simply holds the candidate.
  assign common_ok = CAND_VALID && !MEM_CONFLICT && !INTERRUPT &&
                     !src_conf && !out_conf && !wr_conf;
  // Stack fetches are exempt from the memory restriction during overlap.
  assign scalar_ok = !as_vec && vs_ff != VS_RF &&
                     (!CAND_HAS_DEST || free_any) &&
                     (vs_ff == VS_IDLE || (!vrf_conf &&
                      (!CAND_MEM_REF || CAND_STACK_FETCH)));
  assign vec_go = common_ok && as_vec && vs_ff == VS_IDLE;
  assign ISSUE  = common_ok && (scalar_ok || vec_go) && rst_n;
  assign STALL  = CAND_VALID && !ISSUE;
  assign alloc  = ISSUE && !as_vec && CAND_HAS_DEST;

  // Vector unit tracker: it owns the file until it says it is done with it.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      vs_ff <= VS_IDLE;
    end else begin
      case (vs_ff)
        VS_IDLE: begin
          if (vec_go) begin
            vs_ff <= VS_RF;
          end
        end
        VS_RF: begin
          if (VEC_DONE) begin
            vs_ff <= VS_IDLE;
          end else if (VEC_RF_FREE) begin
            vs_ff <= VS_TAIL;
          end
        end
        VS_TAIL: begin
          if (VEC_DONE) begin
            vs_ff <= VS_IDLE;
          end
        end
        default: begin
          vs_ff <= VS_IDLE;
        end
      endcase
    end
  end

  // Hand-off of the decoded vector instruction and its descriptors.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      VEC_START  <= 1'b0;
      VEC_OPCODE <= 8'h0;
      VEC_DESC   <= '0;
      vreg_a_ff  <= 8'h0;
      vreg_b_ff  <= 8'h0;
      vreg_d_ff  <= 8'h0;
      vgbits_ff  <= 8'h0;
    end else begin
      VEC_START <= vec_go;
      if (vec_go) begin
        VEC_OPCODE <= CAND_OPCODE;
        VEC_DESC   <= CAND_DESC;
        vreg_a_ff  <= CAND_SRC_A;
        vreg_b_ff  <= CAND_SRC_B;
        vreg_d_ff  <= CAND_DEST;
        vgbits_ff  <= CAND_GBITS;
      end
    end
  end

  // Scalar side effects: illegal trap and data flag forwarding.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ILL_TRAP   <= 1'b0;
      FLAG_VALID <= 1'b0;
      FLAG_DATA  <= 8'h0;
    end else begin
      ILL_TRAP   <= ISSUE && !as_vec && cls == CLS_ILLEGAL;
      FLAG_VALID <= ISSUE && cls == CLS_SCALAR && CAND_SETS_FLAG;
      if (ISSUE && cls == CLS_SCALAR && CAND_SETS_FLAG) begin
        FLAG_DATA <= CAND_FLAGS;
      end
    end
  end

  // Two program counters; the vector one is loaded at hand-off.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      scalar_pc_ff <= PC_RESET;
      vector_pc_ff <= PC_RESET;
      cir_ff       <= 32'h0;
    end else if (ISSUE) begin
      scalar_pc_ff <= scalar_pc_ff + PC_STEP;
      if (vec_go) begin
        vector_pc_ff <= scalar_pc_ff;
      end else begin
        cir_ff <= CAND_WORD;
      end
    end
  end

  // Hidden state capture; issue is held off in the interrupt cycle.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SAVE_VALID     <= 1'b0;
      SAVE_SCALAR_PC <= PC_RESET;
      SAVE_VECTOR_PC <= PC_RESET;
      SAVE_VOPCODE   <= 8'h0;
      SAVE_GBITS     <= 8'h0;
      SAVE_CIR       <= 32'h0;
    end else begin
      SAVE_VALID <= INTERRUPT;
      if (INTERRUPT) begin
        SAVE_SCALAR_PC <= scalar_pc_ff;
        SAVE_VECTOR_PC <= vector_pc_ff;
        SAVE_VOPCODE   <= VEC_OPCODE;
        SAVE_GBITS     <= vgbits_ff;
        SAVE_CIR       <= cir_ff;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_vec_take;
    ISSUE && as_vec;
  endsequence
  sequence s_vec_pulse;
    VEC_START ##1 !VEC_START;
  endsequence

  a_issue_free: assert property (common_ok && scalar_ok |-> ISSUE)
    else $error("issue withheld with no conflict");
  a_src_block: assert property (ISSUE |-> !src_conf)
    else $error("issued over a source conflict");
  a_out_block: assert property (ISSUE |-> !out_conf && !wr_conf)
    else $error("issued over an output or write conflict");
  a_chain_mark: assert property (alloc |=> chain_ff[$past(lat) - 4'h1])
    else $error("timing chain not marked");
  a_rf_hold: assert property (vs_ff == VS_RF |-> !(ISSUE && !as_vec))
    else $error("scalar issued while file held");
  a_mem_overlap: assert property (ISSUE && vs_ff == VS_TAIL && CAND_MEM_REF
    |-> CAND_STACK_FETCH)
    else $error("scalar memory reference during vector work");
  a_vec_start: assert property (s_vec_take |=> s_vec_pulse)
    else $error("vector start not a single pulse");
  a_vec_pc: assert property (s_vec_take |=>
    vector_pc_ff == $past(scalar_pc_ff))
    else $error("vector counter not loaded");
  a_save_state: assert property (INTERRUPT |=> SAVE_VALID &&
    SAVE_SCALAR_PC == $past(scalar_pc_ff) && SAVE_CIR == $past(cir_ff))
    else $error("hidden state not saved");
  a_ill_trap: assert property (ISSUE && cls == CLS_ILLEGAL && MONITOR_MODE
    |=> ILL_TRAP)
    else $error("monitor illegal trap missing");
  a_flag_pass: assert property (ISSUE && cls == CLS_SCALAR && CAND_SETS_FLAG
    |=> FLAG_VALID && FLAG_DATA == $past(CAND_FLAGS))
    else $error("data flags not forwarded");

endmodule : issue_ctrl
`default_nettype wire

// ==== src/issue_pkg.sv ====
// Constants, types and opcode classification for the instruction issue control.
package issue_pkg;

  localparam int NUM_RAR = 16;
  localparam int LAT_W   = 4;
  localparam int ADDR_W  = 8;
  localparam int PC_W    = 48;
  localparam int WORD_W  = 32;
  localparam int DESC_W  = 128;
  localparam int GDES_W  = 8;

  localparam logic [PC_W-1:0] PC_RESET = 48'h0;
  localparam logic [PC_W-1:0] PC_STEP  = 48'h1;

  typedef enum logic [1:0] {
    CLS_SCALAR  = 2'h0,
    CLS_VECTOR  = 2'h1,
    CLS_ILLEGAL = 2'h2
  } class_e;

  // Gray along idle, holding the file, finishing without it.
  typedef enum logic [1:0] {
    VS_IDLE = 2'h0,
    VS_RF   = 2'h1,
    VS_TAIL = 2'h3
  } vstate_e;

  // Indexed by the second hex digit; bit n is first hex digit n.
  localparam logic [15:0] VEC_MASK [16] = '{
    16'hf700, 16'hf700, 16'hd700, 16'hd308, 16'hf703, 16'hf702,
    16'hf702, 16'hfb0a, 16'hff07, 16'hff0f, 16'hfa0b, 16'hff0a,
    16'hef02, 16'he882, 16'he003, 16'hf502};
  localparam logic [15:0] ILL_MASK [16] = '{
    16'h0000, 16'h0001, 16'h2001, 16'h2410, 16'h0000, 16'h0000,
    16'h0020, 16'h0431, 16'h0000, 16'h0000, 16'h0550, 16'h0001,
    16'h1000, 16'h0700, 16'h0700, 16'h0200};

  // Both hex digits of the opcode select one constant bit: the second picks the entry, the first its bit.
  function automatic class_e classify(input logic [7:0] op);
    class_e c;
    c = CLS_SCALAR;
    if (VEC_MASK[op[3:0]][op[7:4]]) begin
      c = CLS_VECTOR;
    end else if (ILL_MASK[op[3:0]][op[7:4]]) begin
      c = CLS_ILLEGAL;
    end
    return c;
  endfunction : classify

endpackage : issue_pkg

// ==== test/scalar_vector_issue_control_tb.sv ====
// Self-checking testbench for the scalar/vector issue control.
`timescale 1ns/100ps
`default_nettype none
module scalar_vector_issue_control_tb;
  import issue_pkg::*;
  logic              CLK, RESETN, CAND_VALID, CAND_USE_A, CAND_USE_B;
  logic              CAND_HAS_DEST, CAND_MEM_REF, CAND_STACK_FETCH;
  logic              CAND_SETS_FLAG, MEM_CONFLICT, MONITOR_MODE, INTERRUPT;
  logic              VEC_RF_FREE, VEC_DONE, ISSUE, STALL, VEC_START;
  logic              ILL_TRAP, FLAG_VALID, SAVE_VALID;
  logic [7:0]        CAND_OPCODE, CAND_SRC_A, CAND_SRC_B, CAND_DEST;
  logic [7:0]        CAND_FLAGS, VEC_OPCODE, FLAG_DATA, SAVE_VOPCODE;
  logic [WORD_W-1:0] CAND_WORD, SAVE_CIR;
  logic [GDES_W-1:0] CAND_GBITS, SAVE_GBITS;
  logic [DESC_W-1:0] CAND_DESC, VEC_DESC;
  logic [PC_W-1:0]   SAVE_SCALAR_PC, SAVE_VECTOR_PC;
  logic [LAT_W-1:0]  CAND_LATENCY;
  int                num_errors, samples_checked, cycles;

  issue_ctrl i_issue_ctrl (
    .CLK(CLK), .RESETN(RESETN), .CAND_VALID(CAND_VALID),
    .CAND_OPCODE(CAND_OPCODE), .CAND_WORD(CAND_WORD), .CAND_GBITS(CAND_GBITS),
    .CAND_SRC_A(CAND_SRC_A), .CAND_USE_A(CAND_USE_A), .CAND_SRC_B(CAND_SRC_B),
    .CAND_USE_B(CAND_USE_B), .CAND_DEST(CAND_DEST),
    .CAND_HAS_DEST(CAND_HAS_DEST), .CAND_LATENCY(CAND_LATENCY),
    .CAND_MEM_REF(CAND_MEM_REF), .CAND_STACK_FETCH(CAND_STACK_FETCH),
    .CAND_DESC(CAND_DESC), .CAND_SETS_FLAG(CAND_SETS_FLAG),
    .CAND_FLAGS(CAND_FLAGS), .MEM_CONFLICT(MEM_CONFLICT),
    .MONITOR_MODE(MONITOR_MODE), .INTERRUPT(INTERRUPT),
    .VEC_RF_FREE(VEC_RF_FREE), .VEC_DONE(VEC_DONE), .ISSUE(ISSUE),
    .STALL(STALL), .VEC_START(VEC_START), .VEC_OPCODE(VEC_OPCODE),
    .VEC_DESC(VEC_DESC), .ILL_TRAP(ILL_TRAP), .FLAG_VALID(FLAG_VALID),
    .FLAG_DATA(FLAG_DATA), .SAVE_VALID(SAVE_VALID),
    .SAVE_SCALAR_PC(SAVE_SCALAR_PC), .SAVE_VECTOR_PC(SAVE_VECTOR_PC),
    .SAVE_VOPCODE(SAVE_VOPCODE), .SAVE_GBITS(SAVE_GBITS), .SAVE_CIR(SAVE_CIR));

  vector_unit_model i_vector_unit_model (
    .clk(CLK), .reset_n(RESETN), .start(VEC_START), .rf_dly(5'h3),
    .done_dly(5'h8), .rf_free(VEC_RF_FREE), .done(VEC_DONE));

  // Free-running 200 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      complete_run;
    end
  end

  task automatic check(input string name, input logic [127:0] seen,
                       input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Sets up a candidate; address 0 means unused, ext is flag/mem/stack.
  task automatic cand(input logic [7:0] op, sa, sb, d,
                      input logic [3:0] lat, input logic [2:0] ext);
    CAND_OPCODE      <= op;
    CAND_SRC_A       <= sa;
    CAND_USE_A       <= (sa != 8'h0);
    CAND_SRC_B       <= sb;
    CAND_USE_B       <= (sb != 8'h0);
    CAND_DEST        <= d;
    CAND_HAS_DEST    <= (d != 8'h0);
    CAND_LATENCY     <= lat;
    CAND_WORD        <= {op, sa, sb, d};
    CAND_GBITS       <= ~op;
    CAND_DESC        <= {16{op}};
    CAND_FLAGS       <= op ^ 8'h5a;
    CAND_SETS_FLAG   <= ext[2];
    CAND_MEM_REF     <= ext[1];
    CAND_STACK_FETCH <= ext[0];
  endtask : cand

  // Offers the candidate and checks how many cycles it waited for issue.
  task automatic go(input int exp, input bit keep);
    int n;
    n = 0;
    CAND_VALID <= 1'b1;
    @(negedge CLK);
    while (ISSUE !== 1'b1 && n < 40) begin
      check("stall", STALL, 1'b1);
      n++;
      @(negedge CLK);
    end
    check("wait cycles", n, exp);
    @(posedge CLK);
    if (!keep) begin
      CAND_VALID <= 1'b0;
    end
  endtask : go

  // Lets the result pipeline drain so tests do not disturb each other.
  task automatic done(input string name);
    repeat (8) @(posedge CLK);
    $display("test %s finished", name);
  endtask : done

  task automatic t_src;
    cand(8'h00, 8'h0, 8'h0, 8'h06, 4'h1, 3'h0);
    go(0, 1'b1);
    cand(8'h00, 8'h0, 8'h0, 8'h05, 4'h3, 3'h0);
    go(0, 1'b1);
    cand(8'h00, 8'h09, 8'h05, 8'h0, 4'h1, 3'h0);
    go(3, 1'b0);
    done("source");
  endtask : t_src

  task automatic t_out;
    cand(8'h00, 8'h0, 8'h0, 8'h07, 4'h4, 3'h0);
    go(0, 1'b1);
    cand(8'h00, 8'h0, 8'h0, 8'h07, 4'h1, 3'h0);
    go(4, 1'b1);
    cand(8'h00, 8'h0, 8'h0, 8'h08, 4'h2, 3'h0);
    go(0, 1'b1);
    cand(8'h00, 8'h0, 8'h0, 8'h08, 4'h4, 3'h0);
    go(0, 1'b0);
    done("output");
  endtask : t_out

  task automatic t_wr;
    cand(8'h00, 8'h0, 8'h0, 8'h0a, 4'h4, 3'h0);
    go(0, 1'b1);
    cand(8'h00, 8'h0, 8'h0, 8'h0b, 4'h3, 3'h0);
    go(1, 1'b0);
    done("write port");
  endtask : t_wr

  task automatic t_vec;
    cand(8'h80, 8'h0, 8'h0, 8'h0, 4'h1, 3'h0);
    go(0, 1'b0);
    @(negedge CLK);
    check("vec start", VEC_START, 1'b1);
    check("vec opcode", VEC_OPCODE, 8'h80);
    check("vec desc", VEC_DESC, {16{8'h80}});
    @(posedge CLK);
    cand(8'h00, 8'h0, 8'h0, 8'h21, 4'h1, 3'h0);
    go(3, 1'b1);
    cand(8'h00, 8'h0, 8'h0, 8'h0, 4'h1, 3'h3);
    go(0, 1'b1);
    cand(8'h00, 8'h0, 8'h0, 8'h33, 4'h1, 3'h2);
    go(3, 1'b0);
    done("vector overlap");
  endtask : t_vec

  task automatic t_irq;
    cand(8'h00, 8'h0, 8'h0, 8'h0, 4'h1, 3'h0);
    CAND_VALID <= 1'b1;
    INTERRUPT  <= 1'b1;
    @(negedge CLK);
    check("issue in interrupt", ISSUE, 1'b0);
    @(posedge CLK);
    INTERRUPT    <= 1'b0;
    MEM_CONFLICT <= 1'b1;
    @(negedge CLK);
    check("issue in mem conflict", ISSUE, 1'b0);
    check("save valid", SAVE_VALID, 1'b1);
    check("save vopcode", SAVE_VOPCODE, 8'h80);
    check("save gbits", SAVE_GBITS, 8'h7f);
    check("save cir", SAVE_CIR, 32'h0000_0033);
    // Thirteen issues so far; the hand-off was the tenth of them.
    check("save scalar pc", SAVE_SCALAR_PC, 48'hd);
    check("save vector pc", SAVE_VECTOR_PC, 48'h9);
    @(posedge CLK);
    MEM_CONFLICT <= 1'b0;
    go(0, 1'b0);
    done("interrupt");
  endtask : t_irq

  task automatic t_flag;
    cand(8'h00, 8'h0, 8'h0, 8'h22, 4'h1, 3'h4);
    go(0, 1'b0);
    @(negedge CLK);
    check("flag valid", FLAG_VALID, 1'b1);
    check("flag data", FLAG_DATA, 8'h5a);
    @(posedge CLK);
    done("flags");
  endtask : t_flag

  // The last entry is an illegal opcode in job mode, which goes to vector.
  task automatic t_cls;
    logic [7:0] op_t [7] = '{8'h00, 8'h33, 8'h34, 8'h43, 8'hcc, 8'hb0, 8'h43};
    logic [1:0] cls_t [7] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1};
    for (int i = 0; i < 7; i++) begin
      MONITOR_MODE <= (i < 6);
      cand(op_t[i], 8'h0, 8'h0, 8'h0, 4'h1, 3'h0);
      go(0, 1'b0);
      @(negedge CLK);
      check("vec start", VEC_START, cls_t[i] == 2'h1);
      check("ill trap", ILL_TRAP, cls_t[i] == 2'h2);
      repeat (12) @(posedge CLK);
    end
    done("classes");
  endtask : t_cls

  initial begin
    num_errors      = 0;
    samples_checked = 0;
    cycles          = 0;
    RESETN          <= 1'b0;
    CAND_VALID      <= 1'b0;
    MEM_CONFLICT    <= 1'b0;
    MONITOR_MODE    <= 1'b1;
    INTERRUPT       <= 1'b0;
    cand(8'h00, 8'h0, 8'h0, 8'h0, 4'h1, 3'h0);
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLK);
    t_src;
    t_out;
    t_wr;
    t_vec;
    t_irq;
    t_flag;
    t_cls;
    complete_run;
  end
endmodule : scalar_vector_issue_control_tb
`default_nettype wire

// ==== test/vector_unit_model.sv ====
// Behavioural vector unit that answers hand-offs from the issue control.
`timescale 1ns/100ps
`default_nettype none
module vector_unit_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic [4:0] rf_dly,
  input  wire logic [4:0] done_dly,
  output logic            rf_free,
  output logic            done
);
  logic [4:0] cnt_ff;

  // Cycles since the hand-off; zero means idle and ready for the next one.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 5'h0;
    end else if (start) begin
      cnt_ff <= 5'h1;
    end else if (done) begin
      cnt_ff <= 5'h0;
    end else if (cnt_ff != 5'h0) begin
      cnt_ff <= cnt_ff + 5'h1;
    end
  end

  // The file is released well before the finish, so the scalar side can overlap.
  assign rf_free = (cnt_ff != 5'h0) && (cnt_ff == rf_dly);
  assign done    = (cnt_ff != 5'h0) && (cnt_ff == done_dly);
endmodule : vector_unit_model
`default_nettype wire
